/* File: common/line_pkg.sv */
// Shared constants and types for the serial line front end
package line_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] REG_DATA  = 4'h0;
   localparam logic [3:0] REG_LINE  = 4'h1;
   localparam logic [3:0] REG_MODEM = 4'h2;
   localparam logic [3:0] REG_FEAT  = 4'h3;
   localparam logic [3:0] REG_FCTL  = 4'h4;
   localparam logic [3:0] REG_EMODE = 4'h5;
   localparam logic [3:0] REG_TRIG  = 4'h6;
   localparam logic [3:0] REG_STAT  = 4'h7;
   localparam logic [3:0] REG_DIV   = 4'h8;
   localparam logic [3:0] REG_RXCNT = 4'h9;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int LINE_TWO_STOP = 2;
   localparam int LINE_PAR_EN   = 3;
   localparam int LINE_PAR_EVEN = 4;
   localparam int LINE_TX_OFF   = 5;
   localparam int MODEM_LOOP    = 4;
   localparam int MODEM_IR      = 6;
   localparam int MODEM_PRESC   = 7;
   localparam int FEAT_ENH      = 4;
   localparam int FCTL_DIR      = 3;
   localparam int EMODE_DMA_TX  = 2;
   localparam int ST_RX_AVAIL   = 0;
   localparam int ST_TX_EMPTY   = 1;
   localparam int ST_PAR        = 2;
   localparam int ST_OVR        = 3;
   localparam int ST_FRAME      = 4;
   localparam int ST_TC         = 5;
   localparam int ST_TRIG       = 6;
   // ------------------------------------------------------------
   // Sizes, reset values and counts
   // ------------------------------------------------------------
   localparam int         PTR_W      = 7;
   localparam int         CNT_W      = 8;
   localparam logic [7:0] FIFO_DEPTH = 8'h80;
   localparam logic [7:0] REG_RESET  = 8'h00;
   localparam logic [3:0] TCK_LAST   = 4'hF;
   localparam logic [3:0] TCK_MID    = 4'h7;
   localparam logic [3:0] IR_PULSE   = 4'h3;
   localparam logic [4:0] IR_HOLD    = 5'h10;
   localparam logic [1:0] PRE_LAST   = 2'h3;
   localparam logic [2:0] BIT_LAST   = 3'h7;
   localparam logic [7:0] TRIG_L0    = 8'h08;
   localparam logic [7:0] TRIG_L1    = 8'h20;
   localparam logic [7:0] TRIG_L2    = 8'h40;
   localparam logic [7:0] TRIG_L3    = 8'h70;
   // ------------------------------------------------------------
   // State types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage

/* File: logic/byte_ram.sv */
// 128 x 8 queue storage with registered read and write bypass
`timescale 1ns/1ns
module byte_ram (
   input  wire logic                      ref_clk,
   input  wire logic                      we,
   input  wire logic [line_pkg::PTR_W-1:0] waddr,
   input  wire logic [7:0]                wdata,
   input  wire logic [line_pkg::PTR_W-1:0] raddr,
   output logic      [7:0]                q
);
   import line_pkg::*;
   logic [7:0] mem [0:(1<<PTR_W)-1];

   // Bypass keeps the head word correct when a write lands on an empty queue
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      q <= (we && waddr == raddr) ? wdata : mem[raddr];
   end
endmodule

/* File: logic/serial_front.sv */
// Serial line front end: framing, infrared, loopback, prescale, DMA and direction
`timescale 1ns/1ns
module serial_front (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       serial_rx_in,
   output logic            serial_tx_out,
   input  wire logic       prescale_select_in,
   input  wire logic       dma_enable_n,
   input  wire logic       dma_terminal_count,
   input  wire logic       dma_acknowledge_n,
   output logic            dma_request,
   output logic            direction_control_out,
   output logic            irq_out,
   output logic            irq_oe
);
   import line_pkg::*;

   typedef struct packed {
      logic [7:0]       line, modem, feat, fctl, emode, trig, divisor, rdata;
      logic [1:0]       pre_cnt;
      logic [7:0]       baud_cnt;
      logic             tick, four_x;
      logic [1:0]       psel_s, dma_s, dma_acknowledge_n_s, tc_s, rx_s;
      tx_state_t        tx_st;
      logic [7:0]       tx_sh;
      logic [2:0]       tx_bit;
      logic [3:0]       tx_tck;
      logic             tx_line, tx_pin;
      logic [PTR_W-1:0] tx_wp, tx_rp;
      logic [CNT_W-1:0] tx_cnt;
      rx_state_t        rx_st;
      logic [7:0]       rx_sh;
      logic [2:0]       rx_bit;
      logic [3:0]       rx_tck;
      logic [4:0]       ir_hold;
      logic [PTR_W-1:0] rx_wp, rx_rp;
      logic [CNT_W-1:0] rx_cnt;
      logic             par_err, ovr_err, frm_err, tc_seen;
      logic             dir, dma_req, irq;
   } state_t;

   state_t     s;
   state_t     n;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic       tx_push;
   logic       rx_push;
   logic       pre_tick;
   logic       dir_en;
   logic       rx_bitval;

   function automatic logic parity_bit(input logic [7:0] d, input logic even);
      parity_bit = even ? ^d : ~^d;
   endfunction

   function automatic logic [7:0] trig_level(input logic [1:0] sel);
      case (sel)
         2'h0:    trig_level = TRIG_L0;
         2'h1:    trig_level = TRIG_L1;
         2'h2:    trig_level = TRIG_L2;
         default: trig_level = TRIG_L3;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Queue storage
   // ------------------------------------------------------------
   // two queues
   byte_ram tx_ram (
      .ref_clk (ref_clk),
      .we      (tx_push),
      .waddr   (s.tx_wp),
      .wdata   (wdata),
      .raddr   (n.tx_rp),
      .q       (tx_q)
   );
   byte_ram rx_ram (
      .ref_clk (ref_clk),
      .we      (rx_push),
      .waddr   (s.rx_wp),
      .wdata   (s.rx_sh),
      .raddr   (n.rx_rp),
      .q       (rx_q)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      n        = s;
      tx_push  = 1'b0;
      rx_push  = 1'b0;
      pre_tick = 1'b0;
      dir_en   = s.feat[FEAT_ENH] & s.fctl[FCTL_DIR];
      // Pin synchronisers: only the second stage is read below
      n.psel_s = {s.psel_s[0], prescale_select_in};
      n.dma_s  = {s.dma_s[0], dma_enable_n};
      n.dma_acknowledge_n_s = {s.dma_acknowledge_n_s[0], dma_acknowledge_n};
      n.tc_s   = {s.tc_s[0], dma_terminal_count};
      n.rx_s   = {s.rx_s[0], serial_rx_in};
      n.rdata  = 8'h00;

      // modem bit 7 forces divide by four
      n.four_x  = s.modem[MODEM_PRESC] | ~s.psel_s[1];
      n.pre_cnt = s.pre_cnt + 2'h1;
      pre_tick  = !s.four_x || s.pre_cnt == PRE_LAST;
      n.tick    = 1'b0;
      if (pre_tick) begin
         if (s.baud_cnt == 8'h00) begin
            n.tick     = 1'b1;
            n.baud_cnt = s.divisor;
         end else begin
            n.baud_cnt = s.baud_cnt - 8'h01;
         end
      end

      // Register writes
      if (wr) begin
         case (addr)
            REG_DATA: begin
               if (s.tx_cnt != FIFO_DEPTH) begin
                  tx_push = 1'b1;
               end
            end
            REG_LINE:  n.line    = wdata;
            REG_MODEM: n.modem   = wdata;
            REG_FEAT:  n.feat    = wdata;
            REG_FCTL:  n.fctl    = wdata;
            REG_EMODE: n.emode   = wdata;
            REG_TRIG:  n.trig    = wdata;
            REG_DIV:   n.divisor = wdata;
            default: ;
         endcase
      end

      // Register reads; status read clears the sticky flags
      if (rd) begin
         case (addr)
            REG_DATA: begin
               n.rdata = rx_q;
               if (s.rx_cnt != 8'h00) begin
                  n.rx_rp = s.rx_rp + 7'h01;
               end
            end
            REG_LINE:  n.rdata = s.line;
            REG_MODEM: n.rdata = s.modem;
            REG_FEAT:  n.rdata = s.feat;
            REG_FCTL:  n.rdata = s.fctl;
            REG_EMODE: n.rdata = s.emode;
            REG_TRIG:  n.rdata = s.trig;
            REG_DIV:   n.rdata = s.divisor;
            REG_RXCNT: n.rdata = s.rx_cnt;
            REG_STAT: begin
               n.rdata[ST_RX_AVAIL] = s.rx_cnt != 8'h00;
               n.rdata[ST_TX_EMPTY] = s.tx_cnt == 8'h00 && s.tx_st == TX_IDLE;
               n.rdata[ST_PAR]      = s.par_err;
               n.rdata[ST_OVR]      = s.ovr_err;
               n.rdata[ST_FRAME]    = s.frm_err;
               n.rdata[ST_TC]       = s.tc_seen;
               n.rdata[ST_TRIG]     = s.irq;
               n.par_err = 1'b0;
               n.ovr_err = 1'b0;
               n.frm_err = 1'b0;
               n.tc_seen = 1'b0;
            end
            default: ;
         endcase
      end
      if (tx_push) begin
         n.tx_wp = s.tx_wp + 7'h01;
      end

      case (s.tx_st)
         TX_IDLE: begin
            n.tx_line = 1'b1;
            if (s.tick && s.tx_cnt != 8'h00 && !s.line[LINE_TX_OFF]) begin
               n.tx_sh   = tx_q;
               n.tx_rp   = s.tx_rp + 7'h01;
               n.tx_st   = TX_START;
               n.tx_tck  = 4'h0;
               n.tx_bit  = 3'h0;
               n.tx_line = 1'b0;
            end
         end
         default: begin
            if (s.tick) begin
               n.tx_tck = s.tx_tck + 4'h1;
               if (s.tx_tck == TCK_LAST) begin
                  case (s.tx_st)
                     TX_START: begin
                        n.tx_st   = TX_DATA;
                        n.tx_line = s.tx_sh[0];
                     end
                     TX_DATA: begin
                        n.tx_bit = s.tx_bit + 3'h1;
                        if (s.tx_bit == BIT_LAST) begin
                           n.tx_st   = s.line[LINE_PAR_EN] ? TX_PAR : TX_STOP;
                           n.tx_line = s.line[LINE_PAR_EN] ?
                                       parity_bit(s.tx_sh, s.line[LINE_PAR_EVEN]) : 1'b1;
                           n.tx_bit  = 3'h0;
                        end else begin
                           n.tx_line = s.tx_sh[s.tx_bit + 3'h1];
                        end
                     end
                     TX_PAR: begin
                        n.tx_st   = TX_STOP;
                        n.tx_line = 1'b1;
                     end
                     default: begin
                        n.tx_line = 1'b1;
                        if (s.line[LINE_TWO_STOP] && s.tx_bit == 3'h0) begin
                           n.tx_bit = 3'h1;
                        end else begin
                           n.tx_st = TX_IDLE;
                        end
                     end
                  endcase
               end
            end
         end
      endcase

      // plain idle, disabled or looped pin stays high
      // infrared pin low unless a zero pulse is sent
      if (s.modem[MODEM_LOOP] || s.line[LINE_TX_OFF]) begin
         n.tx_pin = !s.modem[MODEM_IR];
      end else if (s.modem[MODEM_IR]) begin
         n.tx_pin = n.tx_st != TX_IDLE && !n.tx_line && n.tx_tck < IR_PULSE;
      end else begin
         n.tx_pin = n.tx_line;
      end

      // infrared pulse stretched to a whole zero bit
      if (s.modem[MODEM_IR] && s.rx_s[1]) begin
         n.ir_hold = IR_HOLD;
      end else if (s.tick && s.ir_hold != 5'h00) begin
         n.ir_hold = s.ir_hold - 5'h01;
      end
      // receiver fed from own transmit stream
      if (s.modem[MODEM_LOOP]) begin
         rx_bitval = s.tx_line;
      end else if (s.modem[MODEM_IR]) begin
         rx_bitval = s.ir_hold == 5'h00;
      end else begin
         rx_bitval = s.rx_s[1];
      end

      case (s.rx_st)
         RX_IDLE: begin
            if (!rx_bitval) begin
               n.rx_st  = RX_START;
               n.rx_tck = 4'h0;
            end
         end
         RX_START: begin
            if (s.tick) begin
               n.rx_tck = s.rx_tck + 4'h1;
               if (s.rx_tck == TCK_MID) begin
                  n.rx_st  = rx_bitval ? RX_IDLE : RX_DATA;
                  n.rx_tck = 4'h0;
                  n.rx_bit = 3'h0;
               end
            end
         end
         default: begin
            if (s.tick) begin
               n.rx_tck = s.rx_tck + 4'h1;
               if (s.rx_tck == TCK_LAST) begin
                  case (s.rx_st)
                     RX_DATA: begin
                        n.rx_sh  = {rx_bitval, s.rx_sh[7:1]};
                        n.rx_bit = s.rx_bit + 3'h1;
                        if (s.rx_bit == BIT_LAST) begin
                           n.rx_st = s.line[LINE_PAR_EN] ? RX_PAR : RX_STOP;
                        end
                     end
                     RX_PAR: begin
                        n.rx_st = RX_STOP;
                        if (rx_bitval != parity_bit(s.rx_sh, s.line[LINE_PAR_EVEN])) begin
                           n.par_err = 1'b1;
                        end
                     end
                     default: begin
                        n.rx_st = RX_IDLE;
                        if (!rx_bitval) begin
                           n.frm_err = 1'b1;
                        end
                        if (s.rx_cnt == FIFO_DEPTH) begin
                           n.ovr_err = 1'b1;
                        end else begin
                           rx_push = 1'b1;
                           n.rx_wp = s.rx_wp + 7'h01;
                        end
                     end
                  endcase
               end
            end
         end
      endcase

      n.tx_cnt = s.tx_cnt + {7'h00, tx_push} - {7'h00, n.tx_rp != s.tx_rp};
      n.rx_cnt = s.rx_cnt + {7'h00, rx_push} - {7'h00, n.rx_rp != s.rx_rp};

      if (!dir_en) begin
         n.dir = 1'b1;
      end else if (tx_push) begin
         n.dir = 1'b0;
      end else if (s.tx_st == TX_IDLE && s.tx_cnt == 8'h00) begin
         // only after the last stop bit
         n.dir = 1'b1;
      end

      // DMA active only with enable low
      // bit 2 picks the direction of DMA
      if (s.dma_s[1]) begin
         n.dma_req = 1'b0;
      end else begin
         if (s.tc_s[1]) begin
            n.tc_seen = 1'b1;
         end
         n.dma_req = s.dma_acknowledge_n_s[1] && (s.emode[EMODE_DMA_TX] ?
                     n.tx_cnt < FIFO_DEPTH : n.rx_cnt != 8'h00);
      end

      n.irq = n.rx_cnt >= trig_level(s.trig[1:0]);
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s         <= '0;
         s.tx_line <= 1'b1;
         s.tx_pin  <= 1'b1;
         s.dir     <= 1'b1;
         s.psel_s  <= 2'h3;
         s.dma_s   <= 2'h3;
         s.dma_acknowledge_n_s  <= 2'h3;
         s.rx_s    <= 2'h3;
      end else begin
         s <= n;
      end
   end

   assign rdata                 = s.rdata;
   assign serial_tx_out         = s.tx_pin;
   assign dma_request           = s.dma_req;
   assign direction_control_out = s.dir;
   assign irq_out               = s.irq;
   assign irq_oe                = s.irq;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   plain_idle_high_a: assert property (
      s.tx_st == TX_IDLE && !s.modem[MODEM_IR] ##1 $stable(s.modem) && s.tx_st == TX_IDLE
      |-> serial_tx_out)
      else $error("plain idle line not high");
   ir_idle_low_a: assert property (
      s.tx_st == TX_IDLE && s.modem[MODEM_IR] ##1 $stable(s.modem) && s.tx_st == TX_IDLE
      |-> !serial_tx_out)
      else $error("infrared idle line not low");
   loop_pin_idle_a: assert property (
      s.modem[MODEM_LOOP] ##1 $stable(s.modem) |-> serial_tx_out == !s.modem[MODEM_IR])
      else $error("loopback pin not isolated");
   prescale_div_a: assert property (
      $past(s.four_x) && s.four_x && s.tick ##1 s.four_x [*2]
      |-> !$past(s.tick) && !s.tick ##1 !s.tick)
      else $error("divide by four tick spacing wrong");
   dma_off_a: assert property (
      s.dma_s[1] |=> !dma_request)
      else $error("DMA request while disabled");
   dir_to_tx_a: assert property (
      dir_en && wr && addr == REG_DATA && s.tx_cnt != FIFO_DEPTH |=> !direction_control_out)
      else $error("direction did not turn to transmit");
   dir_hold_a: assert property (
      dir_en && !direction_control_out && s.tx_st != TX_IDLE ##1 dir_en
      |-> !direction_control_out)
      else $error("direction turned during a frame");
   dir_off_a: assert property (
      !dir_en |=> direction_control_out)
      else $error("direction not receive when off");
   start_bit_a: assert property (
      s.tx_st == TX_IDLE ##1 s.tx_st == TX_START |-> !s.tx_line)
      else $error("start bit not low");
   queue_bound_a: assert property (
      s.rx_cnt <= FIFO_DEPTH && s.tx_cnt <= FIFO_DEPTH)
      else $error("queue count above depth");
   trig_irq_a: assert property (
      s.rx_cnt >= trig_level(s.trig[1:0]) ##1 $stable(s.trig) && s.rx_cnt == $past(s.rx_cnt)
      |-> irq_oe)
      else $error("trigger interrupt missing");

   frame_sent_c: cover property (s.tx_st == TX_STOP ##1 s.tx_st == TX_IDLE);
   byte_recv_c:  cover property (rx_push);
   dir_turn_c:   cover property (dir_en && $rose(direction_control_out));
   par_err_c:    cover property ($rose(s.par_err));
endmodule

/* File: sim/line_partner.sv */
// Far-end serial line model: frame capture and frame send
`timescale 1ns/1ns
module line_partner (
   input  wire logic       ref_clk,
   input  wire logic       tx,
   input  wire logic       listen,
   input  wire logic       learn,
   input  wire logic       par_on,
   input  wire logic       ir,
   input  wire logic       jam,
   output logic            rx,
   output logic [9:0]      word,
   output int              bit_len,
   output int              frames
);
   logic rx_q;
   int   c;
   int   t;
   assign rx = rx_q & ~ir & ~jam;
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   // Reuses the bit length learnt from the last start bit
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_q = f[i];
         repeat (bit_len) tick();
      end
   endtask
   initial begin
      rx_q = 1'b1;
      word = 10'h000;
      bit_len = 16;
      frames = 0;
      forever begin
         @(negedge tx iff listen);
         c = 0;
         word = 10'h000;
         // Learning needs a one in the first data bit
         if (learn) begin
            while (tx === 1'b0) begin
               tick();
               c++;
            end
            bit_len = c;
         end
         for (int i = 0; i < (par_on ? 10 : 9); i++) begin
            t = bit_len * (i + 1) + bit_len / 2;
            repeat (t - c) tick();
            c = t;
            word[i] = tx;
         end
         frames++;
      end
   end
endmodule

/* File: sim/uart_serial_line_front_end_tb.sv */
// Self-checking bench for the serial line front end
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %s exp %h seen %h", nm, e, g); end end
module uart_serial_line_front_end_tb;
   import line_pkg::*;
   logic        ref_clk, rstn, wr, rd, rd_seen, serial_rx_in, serial_tx_out;
   logic        prescale_select_in, dma_enable_n, dma_terminal_count;
   logic        dma_acknowledge_n, dma_request, direction_control_out, irq_out, irq_oe;
   logic        listen, learn, par_on, even, ir, jam;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, b, e8;
   logic [9:0]  word, e10;
   logic [31:0] seed;
   logic [9:0]  tq[$];
   logic [7:0]  rq[$];
   int          bit_len, frames, failures, num_checks, fast, lows;
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   serial_front dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .serial_rx_in(serial_rx_in),
      .serial_tx_out(serial_tx_out), .prescale_select_in(prescale_select_in),
      .dma_enable_n(dma_enable_n), .dma_terminal_count(dma_terminal_count),
      .dma_acknowledge_n(dma_acknowledge_n), .dma_request(dma_request),
      .direction_control_out(direction_control_out), .irq_out(irq_out), .irq_oe(irq_oe));
   line_partner u_line (.ref_clk(ref_clk), .tx(serial_tx_out), .listen(listen),
      .learn(learn), .par_on(par_on), .ir(ir), .jam(jam), .rx(serial_rx_in),
      .word(word), .bit_len(bit_len), .frames(frames));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // plain register port stands for standard bus
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rreg(input logic [3:0] a, input logic [7:0] e);
      rq.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic put(input logic [7:0] d);
      tq.push_back(par_on ? {1'b1, even ? ^d : ~^d, d} : {2'b01, d});
      wreg(REG_DATA, d);
   endtask
   task automatic wait_frames(input int n);
      for (int k = 0; k < 30000 && frames < n; k++) @(posedge ref_clk);
      `CHK("frames", n, frames)
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------
   // Result watchers
   // ----------------------------------------
   always @(frames) begin
      e10 = tq.pop_front();
      `CHK("frame", e10, word)
   end
   always @(posedge ref_clk) rd_seen <= rd;
   always @(negedge ref_clk) begin
      if (rd_seen) begin
         e8 = rq.pop_front();
         `CHK("rdata", e8, rdata)
      end
   end
   initial begin
      #1000000;
      failures++;
      wrap_up();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rstn, wr, rd, dma_terminal_count, listen, learn, par_on, even, ir, jam} = 10'h000;
      {prescale_select_in, dma_enable_n, dma_acknowledge_n} = 3'h7;
      addr = 4'h0;
      wdata = 8'h00;
      seed = 32'h00015A6A;
      repeat (4) @(posedge ref_clk);
      `CHK("tx_rst", 1'b1, serial_tx_out)
      `CHK("dir_rst", 1'b1, direction_control_out)
      `CHK("irq_rst", 1'b0, irq_oe)
      `CHK("irq_out_rst", 1'b0, irq_out)
      rstn <= 1'b1;
      @(posedge ref_clk);
      rreg(REG_MODEM, 8'h00);
      rreg(4'hF, 8'h00);
      dma_enable_n <= 1'b0;
      wreg(REG_EMODE, 8'h04);
      repeat (4) @(posedge ref_clk);
      `CHK("drq_tx", 1'b1, dma_request)
      dma_acknowledge_n <= 1'b0;
      dma_terminal_count <= 1'b1;
      repeat (4) @(posedge ref_clk);
      `CHK("drq_ack", 1'b0, dma_request)
      dma_acknowledge_n <= 1'b1;
      dma_terminal_count <= 1'b0;
      // Let the released pin pass its synchroniser, else it sets the flag again
      repeat (2) @(posedge ref_clk);
      rreg(REG_STAT, 8'h22);
      rreg(REG_STAT, 8'h02);
      wreg(REG_EMODE, 8'h00);
      repeat (4) @(posedge ref_clk);
      `CHK("drq_rx", 1'b0, dma_request)
      dma_enable_n <= 1'b1;
      wreg(REG_EMODE, 8'h04);
      repeat (4) @(posedge ref_clk);
      `CHK("drq_off", 1'b0, dma_request)
      listen = 1'b1;
      learn = 1'b1;
      put(8'h01);
      wait_frames(1);
      fast = bit_len;
      prescale_select_in <= 1'b0;
      // Pin reaches the prescaler three edges later; start the frame after it
      repeat (4) @(posedge ref_clk);
      put(8'h03);
      wait_frames(2);
      `CHK("div4", fast * 4, bit_len)
      prescale_select_in <= 1'b1;
      wreg(REG_MODEM, 8'h80);
      put(8'h05);
      wait_frames(3);
      `CHK("force4", fast * 4, bit_len)
      wreg(REG_MODEM, 8'h00);
      put(8'h07);
      wait_frames(4);
      learn = 1'b0;
      wreg(REG_FEAT, 8'h10);
      wreg(REG_FCTL, 8'h08);
      put(rnd());
      @(negedge ref_clk);
      `CHK("dir_tx", 1'b0, direction_control_out)
      wait_frames(5);
      `CHK("dir_stop", 1'b0, direction_control_out)
      repeat (fast) @(posedge ref_clk);
      `CHK("dir_rx", 1'b1, direction_control_out)
      repeat (3) put(rnd());
      wait_frames(8);
      par_on = 1'b1;
      wreg(REG_LINE, 8'h08);
      put(rnd());
      wait_frames(9);
      even = 1'b1;
      wreg(REG_LINE, 8'h18);
      put(rnd());
      wait_frames(10);
      par_on = 1'b0;
      wreg(REG_LINE, 8'h20);
      put(rnd());
      repeat (20 * fast) @(posedge ref_clk);
      `CHK("tx_off", 1'b1, serial_tx_out)
      `CHK("no_frame", 10, frames)
      wreg(REG_LINE, 8'h00);
      wait_frames(11);
      b = rnd();
      u_line.send(b);
      repeat (4) @(posedge ref_clk);
      rreg(REG_RXCNT, 8'h01);
      rreg(REG_DATA, b);
      // Partner sends no parity bit, so its stop bit is taken as odd parity
      wreg(REG_LINE, 8'h08);
      b = rnd();
      u_line.send(b);
      repeat (20) @(posedge ref_clk);
      rreg(REG_STAT, {5'h00, ^b, 2'h3});
      rreg(REG_DATA, b);
      wreg(REG_LINE, 8'h00);
      jam <= 1'b1;
      wreg(REG_MODEM, 8'h10);
      b = rnd();
      wreg(REG_DATA, b);
      lows = 0;
      repeat (12 * fast) begin
         @(negedge ref_clk);
         lows += (serial_tx_out !== 1'b1);
      end
      `CHK("loop_tx", 0, lows)
      @(posedge ref_clk);
      rreg(REG_DATA, b);
      jam <= 1'b0;
      wreg(REG_MODEM, 8'h00);
      listen = 1'b0;
      ir <= 1'b1;
      wreg(REG_MODEM, 8'h40);
      repeat (4) @(posedge ref_clk);
      `CHK("ir_idle", 1'b0, serial_tx_out)
      wrap_up();
   end
endmodule
